// ---- timer8_pkg.sv ----
// Package: constants and state types of the 8-bit compare and waveform timer
// Functional notes
// - Count write blocks matches next tick
// - Mode change keeps output states
// - Action select applies at next match
// - Reset clears output states to zero
// - Nonzero action overrides port pin value
// - Action zero leaves output state unchanged
// - Force strobe applies action in non-PWM
// - Mode sets count; action sets output only
// - Normal mode counts up, wraps FF to 00
// - Normal overflow set when reaching zero
// - CTC clears count on channel A match
// - CTC compare unbuffered, may wrap first
// - CTC toggle action gives square wave
// - CTC overflow set passing max to zero
// - Fast PWM top is FF or A
// - Fast PWM clears count after top
// - Fast PWM overflow set at top
// - PWM action two clears, three sets
// - PWM toggle only channel A, top bit
// - PWM compare values double buffered
// - Compare zero spikes, max holds level
// - Match sets channel flag on tick
// - Forced match sets no flag, no clear
// - Count write beats clear or count
// - Clock select zero stops counting
package timer8_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_COUNT = 8'h04;
	localparam logic [7:0] OFS_CMPA = 8'h08;
	localparam logic [7:0] OFS_CMPB = 8'h0C;
	localparam logic [7:0] OFS_FLAGS = 8'h10;
	localparam logic [7:0] OFS_FORCE = 8'h14;
	localparam logic [7:0] OFS_PORT = 8'h18;
	localparam int CTRL_CS_LSB = 3;
	localparam int CTRL_ACTA_LSB = 8;
	localparam int CTRL_ACTB_LSB = 10;
	localparam int PORT_DIR_LSB = 2;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_A = 1;
	localparam int FLAG_B = 2;
	localparam logic [2:0] WGM_NORMAL = 3'h0;
	localparam logic [2:0] WGM_CTC = 3'h2;
	localparam logic [2:0] WGM_FAST = 3'h3;
	localparam logic [2:0] WGM_FAST_TOP = 3'h7;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [9:0] MASK_DIV8 = 10'h007;
	localparam logic [9:0] MASK_DIV64 = 10'h03F;
	localparam logic [9:0] MASK_DIV256 = 10'h0FF;
	localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam logic RST_OUT_STATE = 1'b0;

	typedef struct packed {
		logic [7:0] count;
		logic [7:0] cmp_a_act;
		logic [7:0] cmp_b_act;
		logic [7:0] cmp_a_buf;
		logic [7:0] cmp_b_buf;
		logic [2:0] wgm;
		logic [2:0] cs;
		logic [1:0] act_a;
		logic [1:0] act_b;
		logic [1:0] port_val;
		logic [1:0] dir;
		logic ovf;
		logic flag_a;
		logic flag_b;
		logic block;
		logic ack;
		logic [31:0] rdata;
		logic pin_a;
		logic pin_b;
		logic oe_a;
		logic oe_b;
		logic force_a;
		logic force_b;
		logic match_a;
		logic match_b;
		logic bottom;
	} timer_state_t;

	typedef struct packed {
		logic state;
	} chan_state_t;

	typedef struct packed {
		logic [9:0] pre;
		logic [2:0] sync;
		logic tick;
	} tick_state_t;
endpackage

// ---- tick_divider.sv ----
// Prescaler: turns the clock source select into a one-cycle timer tick enable
`timescale 1ns/1ps
module tick_divider
	import timer8_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [2:0] clock_source_select_in,
	input wire logic ext_count_in,
	output logic tick_out
);
	tick_state_t q;
	tick_state_t d;

	always_comb
	begin
		d = q;
		d.pre = q.pre + 10'h001;
		// First stage feeds only the second one
		d.sync = {q.sync[1], q.sync[0], ext_count_in};
		unique case (clock_source_select_in)
			CS_STOP: d.tick = 1'b0;
			CS_DIV1: d.tick = 1'b1;
			CS_DIV8: d.tick = (q.pre & MASK_DIV8) == MASK_DIV8;
			CS_DIV64: d.tick = (q.pre & MASK_DIV64) == MASK_DIV64;
			CS_DIV256: d.tick = (q.pre & MASK_DIV256) == MASK_DIV256;
			CS_DIV1024: d.tick = q.pre == MASK_DIV1024;
			CS_EXT_FALL: d.tick = q.sync[2] && !q.sync[1];
			default: d.tick = q.sync[1] && !q.sync[2];
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			q <= '0;
		else
			q <= d;
	end

	assign tick_out = q.tick;
endmodule

// ---- compare_channel.sv ----
// One compare output state bit with its set, clear and toggle actions
`timescale 1ns/1ps
module compare_channel
	import timer8_pkg::*;
#(
	parameter bit TOGGLE_IN_PWM = 1'b0
)
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic match_in,
	input wire logic bottom_in,
	input wire logic force_in,
	input wire logic pwm_in,
	input wire logic wgm_top_in,
	input wire logic [1:0] action_in,
	output logic state_out
);
	chan_state_t q;
	chan_state_t d;

	// Toggle makes the CTC square wave
	function automatic logic plain_action(input logic [1:0] act, input logic s);
		unique case (act)
			ACT_TOGGLE: return !s;
			ACT_CLEAR: return 1'b0;
			ACT_SET: return 1'b1;
			default: return s;
		endcase
	endfunction

	always_comb
	begin
		d = q;
		if (!pwm_in)
		begin
			if (force_in || match_in)
				d.state = plain_action(action_in, q.state);
		end
		else
		begin
			if (match_in)
			begin
				unique case (action_in)
					ACT_TOGGLE: d.state = (TOGGLE_IN_PWM && wgm_top_in) ? !q.state : q.state;
					ACT_CLEAR: d.state = 1'b0;
					ACT_SET: d.state = 1'b1;
					default: d.state = q.state;
				endcase
			end
			if (bottom_in && action_in == ACT_CLEAR)
				d.state = 1'b1;
			if (bottom_in && action_in == ACT_SET)
				d.state = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			q.state <= RST_OUT_STATE;
		else
			q <= d;
	end

	assign state_out = q.state;
endmodule

// ---- timer8_compare_waveform.sv ----
// Top: 8-bit timer with two compare channels, waveform modes and Wishbone slave
`timescale 1ns/1ps
module timer8_compare_waveform
	import timer8_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic ext_count_in,
	output logic compare_a_output_out,
	output logic compare_a_oe_out,
	output logic compare_b_output_out,
	output logic compare_b_oe_out,
	output logic [2:0] flags_out
);
	timer_state_t q;
	timer_state_t d;
	logic tick;
	logic state_a;
	logic state_b;
	logic req;
	logic wr;
	logic cnt_wr;
	logic pwm;
	logic at_top;
	logic hit_a;
	logic hit_b;
	logic set_ovf;
	logic [7:0] top;

	tick_divider u_tick (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.clock_source_select_in(q.cs),
		.ext_count_in(ext_count_in),
		.tick_out(tick)
	);

	compare_channel #(
		.TOGGLE_IN_PWM(1'b1)
	) u_chan_a (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.match_in(q.match_a),
		.bottom_in(q.bottom),
		.force_in(q.force_a),
		.pwm_in(pwm),
		.wgm_top_in(q.wgm[2]),
		.action_in(q.act_a),
		.state_out(state_a)
	);

	compare_channel #(
		.TOGGLE_IN_PWM(1'b0)
	) u_chan_b (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.match_in(q.match_b),
		.bottom_in(q.bottom),
		.force_in(q.force_b),
		.pwm_in(pwm),
		.wgm_top_in(q.wgm[2]),
		.action_in(q.act_b),
		.state_out(state_b)
	);

	assign pwm = q.wgm == WGM_FAST || q.wgm == WGM_FAST_TOP;
	assign top = (q.wgm == WGM_FAST_TOP) ? q.cmp_a_act : COUNT_MAX;
	assign at_top = q.count == top;
	assign req = wb_cyc_in && wb_stb_in;
	assign wr = req && wb_we_in && q.ack;
	assign cnt_wr = wr && wb_sel_in[0] && wb_adr_in == OFS_COUNT;

	always_comb
	begin
		d = q;
		d.ack = req && !q.ack;
		d.rdata = 32'h0000_0000;
		d.force_a = 1'b0;
		d.force_b = 1'b0;
		d.match_a = 1'b0;
		d.match_b = 1'b0;
		d.bottom = 1'b0;
		set_ovf = 1'b0;
		hit_a = !q.block && q.count == q.cmp_a_act;
		hit_b = !q.block && q.count == q.cmp_b_act;
		if (tick)
		begin
			d.block = 1'b0;
			d.match_a = hit_a && !(pwm && q.act_a[1] && q.cmp_a_act == top);
			d.match_b = hit_b && !(pwm && q.act_b[1] && q.cmp_b_act == top);
			unique case (q.wgm)
				WGM_CTC:
				begin
					d.count = hit_a ? COUNT_BOTTOM : q.count + 8'h01;
					set_ovf = q.count == COUNT_MAX;
				end
				WGM_FAST, WGM_FAST_TOP:
				begin
					if (at_top)
					begin
						d.count = COUNT_BOTTOM;
						d.bottom = 1'b1;
						d.cmp_a_act = q.cmp_a_buf;
						d.cmp_b_act = q.cmp_b_buf;
					end
					else
						d.count = q.count + 8'h01;
					set_ovf = at_top;
				end
				default:
				begin
					d.count = q.count + 8'h01;
					set_ovf = q.count == COUNT_MAX;
				end
			endcase
		end
		if (wr && wb_sel_in[0])
		begin
			unique case (wb_adr_in)
				OFS_CTRL:
				begin
					d.wgm = wb_dat_in[2:0];
					d.cs = wb_dat_in[CTRL_CS_LSB +: 3];
				end
				OFS_COUNT:
				begin
					d.count = wb_dat_in[7:0];
					d.block = 1'b1;
				end
				OFS_CMPA:
				begin
					d.cmp_a_buf = wb_dat_in[7:0];
					if (!pwm)
						d.cmp_a_act = wb_dat_in[7:0];
				end
				OFS_CMPB:
				begin
					d.cmp_b_buf = wb_dat_in[7:0];
					if (!pwm)
						d.cmp_b_act = wb_dat_in[7:0];
				end
				OFS_FORCE:
				begin
					d.force_a = wb_dat_in[0] && !pwm;
					d.force_b = wb_dat_in[1] && !pwm;
				end
				OFS_PORT:
				begin
					d.port_val = wb_dat_in[1:0];
					d.dir = wb_dat_in[PORT_DIR_LSB +: 2];
				end
				default:
				begin
				end
			endcase
		end
		if (wr && wb_sel_in[1] && wb_adr_in == OFS_CTRL)
		begin
			d.act_a = wb_dat_in[CTRL_ACTA_LSB +: 2];
			d.act_b = wb_dat_in[CTRL_ACTB_LSB +: 2];
		end
		// Set beats a clear in the same cycle so no event is lost
		if (wr && wb_sel_in[0] && wb_adr_in == OFS_FLAGS)
		begin
			d.ovf = q.ovf && !wb_dat_in[FLAG_OVF];
			d.flag_a = q.flag_a && !wb_dat_in[FLAG_A];
			d.flag_b = q.flag_b && !wb_dat_in[FLAG_B];
		end
		if (d.match_a || (tick && hit_a))
			d.flag_a = 1'b1;
		if (d.match_b || (tick && hit_b))
			d.flag_b = 1'b1;
		if (set_ovf)
			d.ovf = 1'b1;
		if (req && !q.ack)
		begin
			unique case (wb_adr_in)
				OFS_CTRL:
				begin
					d.rdata[2:0] = q.wgm;
					d.rdata[CTRL_CS_LSB +: 3] = q.cs;
					d.rdata[CTRL_ACTA_LSB +: 2] = q.act_a;
					d.rdata[CTRL_ACTB_LSB +: 2] = q.act_b;
				end
				OFS_COUNT: d.rdata[7:0] = q.count;
				OFS_CMPA: d.rdata[7:0] = q.cmp_a_buf;
				OFS_CMPB: d.rdata[7:0] = q.cmp_b_buf;
				OFS_FLAGS: d.rdata[2:0] = {q.flag_b, q.flag_a, q.ovf};
				OFS_PORT: d.rdata[3:0] = {q.dir, q.port_val};
				default: d.rdata = 32'h0000_0000;
			endcase
		end
		d.pin_a = (q.act_a != ACT_NONE) ? state_a : q.port_val[0];
		d.pin_b = (q.act_b != ACT_NONE) ? state_b : q.port_val[1];
		d.oe_a = q.dir[0];
		d.oe_b = q.dir[1];
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
			q <= '0;
		else
			q <= d;
	end

	assign wb_dat_out = q.rdata;
	assign wb_ack_out = q.ack;
	assign compare_a_output_out = q.pin_a;
	assign compare_a_oe_out = q.oe_a;
	assign compare_b_output_out = q.pin_b;
	assign compare_b_oe_out = q.oe_b;
	assign flags_out = {q.flag_b, q.flag_a, q.ovf};

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!resetn_in);

	property p_block_match;
		tick && q.block |=> !q.match_a && !q.match_b;
	endproperty
	a_block_match: assert property (p_block_match)
		else $error("match seen in blocked tick");

	property p_normal_wrap;
		tick && !cnt_wr && q.wgm == WGM_NORMAL && q.count == COUNT_MAX
			|=> q.count == COUNT_BOTTOM && q.ovf;
	endproperty
	a_normal_wrap: assert property (p_normal_wrap)
		else $error("normal wrap or overflow wrong");

	property p_ctc_clear;
		tick && !cnt_wr && q.wgm == WGM_CTC && hit_a |=> q.count == COUNT_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear)
		else $error("ctc did not clear");

	property p_pwm_top;
		tick && !cnt_wr && pwm && at_top |=> q.count == COUNT_BOTTOM && q.ovf && q.bottom;
	endproperty
	a_pwm_top: assert property (p_pwm_top)
		else $error("fast pwm top handling wrong");

	property p_cnt_write;
		cnt_wr |=> q.count == $past(wb_dat_in[7:0]) && q.block;
	endproperty
	a_cnt_write: assert property (p_cnt_write)
		else $error("count write lost");

	property p_stopped;
		$past(q.cs) == CS_STOP && q.cs == CS_STOP && !cnt_wr |=> $stable(q.count);
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("count moved while stopped");

	property p_shadow;
		pwm && !(tick && at_top) |=> $stable(q.cmp_a_act) && $stable(q.cmp_b_act);
	endproperty
	a_shadow: assert property (p_shadow)
		else $error("pwm compare not buffered");

	property p_override;
		q.act_a != ACT_NONE |=> compare_a_output_out == $past(state_a);
	endproperty
	a_override: assert property (p_override)
		else $error("pin not overridden");

	property p_flag;
		q.match_a |-> q.flag_a;
	endproperty
	a_flag: assert property (p_flag)
		else $error("match flag missing");

	property p_mode_keep;
		$changed(q.wgm) && !q.match_a && !q.bottom && !q.force_a |=> $stable(state_a);
	endproperty
	a_mode_keep: assert property (p_mode_keep)
		else $error("state changed on mode switch");

	property p_ctc_ovf;
		tick && q.wgm == WGM_CTC && q.count == COUNT_MAX |=> q.ovf;
	endproperty
	a_ctc_ovf: assert property (p_ctc_ovf)
		else $error("ctc overflow not set");

	property p_ovf_hold;
		q.ovf && !(wr && wb_sel_in[0] && wb_adr_in == OFS_FLAGS) |=> q.ovf;
	endproperty
	a_ovf_hold: assert property (p_ovf_hold)
		else $error("overflow cleared by counter");

	property p_force_quiet;
		q.force_a && !tick && !wr |=> $stable(q.flag_a) && $stable(q.count);
	endproperty
	a_force_quiet: assert property (p_force_quiet)
		else $error("forced match touched flag or count");

	property p_act_zero;
		q.act_a == ACT_NONE |=> $stable(state_a);
	endproperty
	a_act_zero: assert property (p_act_zero)
		else $error("state moved with action zero");

	property p_bottom_set;
		pwm && q.bottom && q.act_b == ACT_CLEAR |=> state_b;
	endproperty
	a_bottom_set: assert property (p_bottom_set)
		else $error("pwm output not set at bottom");

	property p_tick_gate;
		!tick && !wr |=> $stable(q.count);
	endproperty
	a_tick_gate: assert property (p_tick_gate)
		else $error("count moved without tick");

	c_ctc: cover property (tick && q.wgm == WGM_CTC && hit_a ##1 q.count == COUNT_BOTTOM);
	c_pwm: cover property (tick && q.wgm == WGM_FAST_TOP && at_top);
	c_force: cover property (q.force_a ##1 $changed(state_a));
	c_ovf: cover property (tick && q.wgm == WGM_CTC && q.count == COUNT_MAX);
endmodule

// ---- pin_load.sv ----
// External load on one compare pin, with a pull-down
`timescale 1ns/1ps
module pin_load
(
	input wire logic drive_in,
	input wire logic oe_in,
	output logic level_out
);
	// pin follows value only while driven
	// Released pin falls to the pull-down, never keeps the last value
	assign level_out = oe_in ? drive_in : 1'b0;
endmodule

// ---- timer8_compare_waveform_tb.sv ----
// Self-checking bench for the compare and waveform timer
`timescale 1ns/1ps
module timer8_compare_waveform_tb;
	import timer8_pkg::*;
	typedef struct packed {
		logic [7:0] adr;
		logic [31:0] wd;
		logic [31:0] ex;
	} row_t;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wd = 32'h0;
	logic ext = 1'b0;
	logic [31:0] rd, q;
	logic ack, pa, pa_oe, pb, pb_oe, lvl_a, lvl_b;
	logic [2:0] flags;
	int n_fail = 0;
	int cmp_count = 0;
	int hi, tog;
	row_t rows [6] = '{'{OFS_CTRL, 32'hF02, 32'hF02}, '{OFS_COUNT, 32'h5A, 32'h5A},
		'{OFS_CMPA, 32'hA5, 32'hA5}, '{OFS_CMPB, 32'h3C, 32'h3C},
		'{OFS_PORT, 32'h0F, 32'h0F}, '{8'h1C, 32'hFF, 32'h00}};
	always #12.5 clk = ~clk;
	timer8_compare_waveform u_dut (.ref_clk_in(clk), .resetn_in(rstn), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd),
		.wb_dat_out(rd), .wb_ack_out(ack), .ext_count_in(ext), .compare_a_output_out(pa),
		.compare_a_oe_out(pa_oe), .compare_b_output_out(pb), .compare_b_oe_out(pb_oe),
		.flags_out(flags));
	pin_load u_load_a (.drive_in(pa), .oe_in(pa_oe), .level_out(lvl_a));
	pin_load u_load_b (.drive_in(pb), .oe_in(pb_oe), .level_out(lvl_b));
	function automatic logic [31:0] ctrl(logic [1:0] ab, logic [1:0] aa, logic [2:0] cs,
		logic [2:0] wgm);
		return 32'({ab, aa, 2'b00, cs, wgm});
	endfunction
	task automatic fail(input string m);
		n_fail++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] ex, input string m);
		cmp_count++;
		if (got !== ex)
			fail(m);
	endtask
	task automatic rng(input int v, input int lo, input int up, input string m);
		cmp_count++;
		if (v < lo || v > up)
			fail(m);
	endtask
	// Request held until ack is sampled, then released for a cycle; only the watchdog ends a wait
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		sel <= 4'h3;
		do
		begin
			@(posedge clk);
		end
		while (ack !== 1'b1);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic meas(input int n, input logic b);
		logic last;
		hi = 0;
		tog = 0;
		last = b ? lvl_b : lvl_a;
		repeat (n)
		begin
			@(posedge clk);
			if ((b ? lvl_b : lvl_a) !== last)
				tog++;
			last = b ? lvl_b : lvl_a;
			if (last === 1'b1)
				hi++;
		end
	endtask
	task automatic summarize();
		$display("checks %0d failures %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#(25 * 20000);
		fail("timeout");
		summarize();
	end
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		chk({pa, pb, pa_oe, pb_oe, flags}, 32'h0, "outputs after reset");
		// Registers written and read with the timer stopped
		foreach (rows[i])
		begin
			wb(1'b1, rows[i].adr, rows[i].wd);
			wb(1'b0, rows[i].adr, 32'h0);
			chk(q, rows[i].ex, "register readback");
		end
		repeat (3) @(posedge clk);
		chk({lvl_a, lvl_b}, 32'h0, "state overrides port value");
		wb(1'b1, OFS_CTRL, 32'h0);
		repeat (3) @(posedge clk);
		chk({lvl_a, lvl_b}, 32'h3, "port value with action zero");
		wb(1'b1, OFS_PORT, 32'h04);
		wb(1'b1, OFS_CTRL, ctrl(ACT_NONE, ACT_SET, CS_STOP, WGM_NORMAL));
		wb(1'b1, OFS_FORCE, 32'h1);
		repeat (3) @(posedge clk);
		chk(lvl_a, 1'b1, "force set");
		wb(1'b1, OFS_CTRL, ctrl(ACT_NONE, ACT_TOGGLE, CS_STOP, WGM_CTC));
		repeat (3) @(posedge clk);
		chk(lvl_a, 1'b1, "state kept across mode change");
		wb(1'b1, OFS_FORCE, 32'h1);
		repeat (3) @(posedge clk);
		chk(lvl_a, 1'b0, "force toggle");
		wb(1'b0, OFS_FLAGS, 32'h0);
		chk(q, 32'h0, "forced match sets no flag");
		wb(1'b0, OFS_COUNT, 32'h0);
		chk(q, 32'h5A, "forced match leaves count");
		// Square wave: toggle every 4 ticks with top 3, every tick with top 0
		wb(1'b1, OFS_CMPA, 32'h03);
		wb(1'b1, OFS_COUNT, 32'h00);
		wb(1'b1, OFS_CTRL, ctrl(ACT_NONE, ACT_TOGGLE, CS_DIV1, WGM_CTC));
		repeat (10) @(posedge clk);
		meas(80, 1'b0);
		rng(tog, 19, 21, "toggle rate with top 3");
		wb(1'b1, OFS_CMPA, 32'h00);
		repeat (300) @(posedge clk);
		meas(40, 1'b0);
		rng(tog, 38, 40, "toggle rate with top 0");
		// Count write equal to compare value blocks that match
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b1, OFS_FLAGS, 32'h7);
		wb(1'b1, OFS_CMPA, 32'hF0);
		wb(1'b1, OFS_COUNT, 32'hF0);
		wb(1'b1, OFS_CTRL, ctrl(ACT_NONE, ACT_NONE, CS_DIV1, WGM_NORMAL));
		repeat (40) @(posedge clk);
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b0, OFS_FLAGS, 32'h0);
		chk(q, 32'h1, "overflow set, blocked match");
		chk(flags, 32'h1, "flag outputs");
		wb(1'b0, OFS_COUNT, 32'h0);
		chk(q[7:6], 2'b00, "count wrapped");
		wb(1'b1, OFS_FLAGS, 32'h1);
		wb(1'b0, OFS_FLAGS, 32'h0);
		chk(q, 32'h0, "overflow cleared by one");
		// Fast PWM duty tracks the buffered compare value
		wb(1'b1, OFS_CMPB, 32'h80);
		wb(1'b1, OFS_PORT, 32'h08);
		wb(1'b1, OFS_CTRL, ctrl(ACT_CLEAR, ACT_NONE, CS_DIV1, WGM_FAST));
		repeat (300) @(posedge clk);
		meas(512, 1'b1);
		rng(hi, 254, 262, "non-inverted duty");
		wb(1'b1, OFS_CMPB, 32'h40);
		repeat (600) @(posedge clk);
		meas(512, 1'b1);
		rng(hi, 126, 134, "duty after buffered update");
		wb(1'b1, OFS_CTRL, ctrl(ACT_SET, ACT_NONE, CS_DIV1, WGM_FAST));
		repeat (300) @(posedge clk);
		meas(512, 1'b1);
		rng(hi, 378, 386, "inverted duty");
		// External rising edges advance the count one each
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b1, OFS_COUNT, 32'h0);
		wb(1'b1, OFS_CTRL, ctrl(ACT_NONE, ACT_NONE, 3'h7, WGM_NORMAL));
		repeat (10)
		begin
			ext <= 1'b1;
			repeat (4) @(posedge clk);
			ext <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (6) @(posedge clk);
		wb(1'b1, OFS_CTRL, 32'h0);
		wb(1'b0, OFS_COUNT, 32'h0);
		chk(q, 32'h0A, "external edge count");
		// Mid-run reset must clear states that were forced high
		wb(1'b1, OFS_PORT, 32'h0C);
		wb(1'b1, OFS_CTRL, ctrl(ACT_SET, ACT_SET, CS_STOP, WGM_NORMAL));
		wb(1'b1, OFS_FORCE, 32'h3);
		repeat (3) @(posedge clk);
		chk({lvl_a, lvl_b}, 32'h3, "both states forced high");
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		chk({pa, pb, pa_oe, pb_oe, flags}, 32'h0, "outputs after mid-run reset");
		wb(1'b1, OFS_PORT, 32'h0C);
		wb(1'b1, OFS_CTRL, ctrl(ACT_SET, ACT_SET, CS_STOP, WGM_NORMAL));
		repeat (3) @(posedge clk);
		chk({lvl_a, lvl_b}, 32'h0, "states cleared by reset");
		summarize();
	end
endmodule
